// ===== logic/exec_params.svh
// Offsets, field positions, reset values and opcode patterns of the execution block
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

// ==========================================================
// Register byte offsets (low address byte)
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_WDT 8'h08
`define OFF_PC 8'h0C
`define FILE_WIN_BIT 7

// ==========================================================
// Field positions
`define CTRL_WDT_EN 0
`define STAT_Z 0
`define STAT_POWER_DOWN 1
`define STAT_TIMEOUT 2
`define WDT_PRE_LSB 16

// ==========================================================
// Reset values
`define CTRL_RST 1'b0
`define Z_RST 1'b0
`define POWER_DOWN_RST 1'b1
`define TIMEOUT_RST 1'b1
`define PC_RST 12'h000
`define FILE_RST 8'h00

// ==========================================================
// Opcode patterns
`define OPC_WDT_CLR 12'h004
`define OPC_BCLR_HI 4'h4
`define OPC_DEC_HI 7'h07
`define OPC_DECSZ_HI 7'h17

`endif

// ===== logic/exec_pkg.sv
// Types shared by the execution block files
package exec_pkg;

    // ==========================================================
    // Sequencer states
    typedef enum logic [0:0] {ST_RUN, ST_SKIP} exec_state_e;

    // ==========================================================
    // Decoded instruction class
    typedef enum logic [2:0] {OP_OTHER, OP_WDT_CLR, OP_BIT_CLR, OP_DEC, OP_DECSZ} op_kind_e;

endpackage : exec_pkg

// ===== logic/opcode_decoder.sv
// Opcode decoder for the clear and decrement instructions
`timescale 1ns/1ns
`include "exec_params.svh"

module opcode_decoder (
    // Instruction in
    input wire logic [11:0] instr_word,
    // Decoded fields
    output exec_pkg::op_kind_e kind,
    output logic [2:0] bit_sel,
    output logic [4:0] file_register_operand
);

    // ==========================================================
    // Pattern matches
    wire is_wdt = instr_word == `OPC_WDT_CLR;
    wire is_bclr = instr_word[11:8] == `OPC_BCLR_HI;
    wire is_dec = instr_word[11:5] == `OPC_DEC_HI;
    wire is_decsz = instr_word[11:5] == `OPC_DECSZ_HI;

    // Exact match first so the fixed word cannot alias a field form
    assign kind = is_wdt ? exec_pkg::OP_WDT_CLR :
                  is_bclr ? exec_pkg::OP_BIT_CLR :
                  is_dec ? exec_pkg::OP_DEC :
                  is_decsz ? exec_pkg::OP_DECSZ : exec_pkg::OP_OTHER;

    // Operand fields: 3-bit bit number, 5-bit file address
    assign bit_sel = instr_word[7:5];
    assign file_register_operand = instr_word[4:0];

endmodule : opcode_decoder

// ===== logic/clear_decrement_instr_exec.sv
// Execution unit for watchdog clear, bit clear, decrement and decrement-skip
// Behaviour
// - Watchdog clear zeroes watchdog counter and prescaler in one instruction cycle.
// - Watchdog clear also sets zero, timeout and power-down flags.
// - Pattern 0100 bbbf ffff is bit clear; b picks bit, f picks register.
// - Bit clear zeroes only the chosen bit, no flags, one cycle.
// - Bit clear reaches registers 00h to 1Fh and bits 0 to 7.
// - Pattern 0000 111f ffff decrements the register and writes back, one cycle.
// - Plain decrement sets zero flag only when 01h becomes 00h, else clears.
// - Decrementing 00h wraps to FFh.
// - Pattern 0010 111f ffff decrements and writes back, flags untouched.
// - Zero result skips next instruction, two cycles; else one cycle.
`timescale 1ns/1ns
`include "exec_params.svh"

module clear_decrement_instr_exec #(
    parameter int PRE_W = 8,
    parameter int WDT_W = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Instruction stream from fetch
    input wire logic instr_valid,
    input wire logic [11:0] instr_word,
    // Core state out
    output logic instr_done,
    output logic skip_active,
    output logic [11:0] pc,
    output logic wdt_timeout
);

    // ==========================================================
    // Bus slave: writes take no wait, reads one wait state
    logic rd_pend_q;
    logic rd_ok_q;
    logic wr_pend_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;

    wire bus_take = hsel & hready & htrans[1];

    // Word map of the low address byte
    //   00h control: bit 0 watchdog enable
    //   04h status: bit 0 zero, bit 1 power-down, bit 2 timeout
    //   08h watchdog: counter low, prescaler from bit 16, read only
    //   0Ch program counter, read only
    //   80h-FCh file registers 00h-1Fh, low byte of each word
    // Size and burst type are not checked; only whole words are expected

    // Timing summary
    //   An instruction takes effect at the edge where it is valid
    //   instr_done and the new pc follow one cycle later
    //   A taken skip costs one further valid slot, with no effect
    //   Reads answer after one wait state, writes with none

    // Read data is fetched in the data phase so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_pend_q <= 1'b0;
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else if (bus_take)
        begin
            rd_pend_q <= ~hwrite;
            wr_pend_q <= hwrite;
            addr_q <= haddr[7:0];
        end
        else if (hreadyout)
        begin
            rd_pend_q <= 1'b0;
            wr_pend_q <= 1'b0;
        end
    end

    // Read wait flag and data register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_ok_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            rd_ok_q <= rd_pend_q & ~rd_ok_q;
            if (rd_pend_q & ~rd_ok_q)
                hrdata_q <= rd_mux;
        end
    end

    assign hreadyout = ~rd_pend_q | rd_ok_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Word decode of the control words, shared by write strobes and read mux
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        return ~a[`FILE_WIN_BIT] & (a == off);
    endfunction : reg_hit

    // Address decode of the latched data-phase address
    wire a_file = addr_q[`FILE_WIN_BIT];
    wire a_ctrl = reg_hit(addr_q, `OFF_CTRL);
    wire a_stat = reg_hit(addr_q, `OFF_STATUS);
    wire a_wdt = reg_hit(addr_q, `OFF_WDT);
    wire a_pc = reg_hit(addr_q, `OFF_PC);

    // Write strobes last only the one data-phase cycle
    wire wr_ctrl = wr_pend_q & a_ctrl;
    wire wr_stat = wr_pend_q & a_stat;
    wire wr_file = wr_pend_q & a_file;
    wire [4:0] bus_fidx = addr_q[6:2];

    // ==========================================================
    // Architectural state
    exec_pkg::exec_state_e state_q;
    exec_pkg::exec_state_e state_d;
    logic ctrl_wdt_en_q;
    logic z_q;
    logic power_down_flag_q;
    logic timeout_flag_q;
    logic [11:0] pc_q;
    logic instr_done_q;
    logic wdt_timeout_q;
    logic [PRE_W-1:0] pre_q;
    logic [WDT_W-1:0] wdt_q;
    logic [7:0] file_q [32];

    // ==========================================================
    // Decode and datapath
    exec_pkg::op_kind_e kind;
    logic [2:0] bit_sel;
    logic [4:0] file_register_operand;

    // Decoder is pure logic; the word is used in the cycle it is valid
    opcode_decoder u_dec (
        .instr_word(instr_word),
        .kind(kind),
        .bit_sel(bit_sel),
        .file_register_operand(file_register_operand)
    );

    // Slot qualifiers; a skip slot swallows whatever word arrives
    wire run_fire = instr_valid & (state_q == exec_pkg::ST_RUN);
    wire skip_fire = instr_valid & (state_q == exec_pkg::ST_SKIP);
    wire do_wdt = run_fire & (kind == exec_pkg::OP_WDT_CLR);
    wire do_bclr = run_fire & (kind == exec_pkg::OP_BIT_CLR);
    wire do_dec = run_fire & (kind == exec_pkg::OP_DEC);
    wire do_decsz = run_fire & (kind == exec_pkg::OP_DECSZ);

    // Operand fetch and results; 00h minus one wraps to FFh
    wire [7:0] opnd_val = file_q[file_register_operand];
    wire [7:0] dec_val = opnd_val - 8'h01;
    wire dec_zero = dec_val == 8'h00;
    wire [7:0] bit_mask = 8'h01 << bit_sel;
    wire [7:0] bclr_val = opnd_val & ~bit_mask;

    // One write port serves all three register-modifying instructions
    wire opnd_we = do_bclr | do_dec | do_decsz;
    wire [7:0] opnd_wdata = do_bclr ? bclr_val : dec_val;
    wire take_skip = do_decsz & dec_zero;

    // ==========================================================
    // Watchdog counters; a software clear beats an expiry
    // The two widths together set the expiry period in cycles
    wire pre_wrap = &pre_q;
    wire wdt_expire = ctrl_wdt_en_q & pre_wrap & (&wdt_q);
    wire wdt_fire = wdt_expire & ~do_wdt;

    // Both counters wrap to zero after an expiry and keep running
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre_q <= '0;
            wdt_q <= '0;
            wdt_timeout_q <= 1'b0;
        end
        else
        begin
            wdt_timeout_q <= wdt_fire;
            if (do_wdt)
            begin
                pre_q <= '0;
                wdt_q <= '0;
            end
            else if (ctrl_wdt_en_q)
            begin
                pre_q <= pre_q + 1'b1;
                if (pre_wrap)
                    wdt_q <= wdt_q + 1'b1;
            end
        end
    end

    // ==========================================================
    // Control register, software written
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_wdt_en_q <= `CTRL_RST;
        else if (wr_ctrl)
            ctrl_wdt_en_q <= hwdata[`CTRL_WDT_EN];
    end

    // ==========================================================
    // Status flags: instruction updates land after a bus write, so they win
    // An expiry clears timeout even when software writes status that cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            z_q <= `Z_RST;
            power_down_flag_q <= `POWER_DOWN_RST;
            timeout_flag_q <= `TIMEOUT_RST;
        end
        else
        begin
            if (wr_stat)
            begin
                z_q <= hwdata[`STAT_Z];
                power_down_flag_q <= hwdata[`STAT_POWER_DOWN];
                timeout_flag_q <= hwdata[`STAT_TIMEOUT];
            end
            if (wdt_fire)
                timeout_flag_q <= 1'b0;
            if (do_wdt)
            begin
                z_q <= 1'b1;
                power_down_flag_q <= 1'b1;
                timeout_flag_q <= 1'b1;
            end
            if (do_dec)
                z_q <= dec_zero;
        end
    end

    // ==========================================================
    // File registers, one slice per address; the executing instruction beats a bus write
    // A bus write colliding with an instruction on the same register is lost
    for (genvar g = 0; g < 32; g++)
    begin : g_file
        wire bus_hit = wr_file & (bus_fidx == 5'(g));
        wire ins_hit = opnd_we & (file_register_operand == 5'(g));

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
                file_q[g] <= `FILE_RST;
            else if (ins_hit)
                file_q[g] <= opnd_wdata;
            else if (bus_hit)
                file_q[g] <= hwdata[7:0];
        end
    end

    // ==========================================================
    // Sequencer: the skip slot eats one instruction with no side effect
    // The skip waits as long as needed for the next valid word
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            exec_pkg::ST_RUN:
                if (take_skip)
                    state_d = exec_pkg::ST_SKIP;
            exec_pkg::ST_SKIP:
                if (skip_fire)
                    state_d = exec_pkg::ST_RUN;
            default:
                state_d = exec_pkg::ST_RUN;
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_q <= exec_pkg::ST_RUN;
        else
            state_q <= state_d;
    end

    // Program counter steps for every slot, skipped or not
    // Jumps are outside this block, so the count only ever advances by one
    wire [11:0] pc_d = pc_q + 12'h001;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pc_q <= `PC_RST;
            instr_done_q <= 1'b0;
        end
        else
        begin
            instr_done_q <= run_fire | skip_fire;
            if (run_fire | skip_fire)
                pc_q <= pc_d;
        end
    end

    // Registered outputs to the rest of the core
    assign instr_done = instr_done_q;
    assign skip_active = state_q == exec_pkg::ST_SKIP;
    assign pc = pc_q;
    assign wdt_timeout = wdt_timeout_q;

    // ==========================================================
    // Read mux; unmapped words read as zero
    // Prescaler sits high so the counter reads as a plain number
    wire [31:0] wdt_word = 32'(wdt_q) | (32'(pre_q) << `WDT_PRE_LSB);

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (a_file)
            rd_mux = {24'h00_0000, file_q[bus_fidx]};
        else if (a_ctrl)
            rd_mux = {31'h0000_0000, ctrl_wdt_en_q};
        else if (a_stat)
            rd_mux = {29'h0000_0000, timeout_flag_q, power_down_flag_q, z_q};
        else if (a_wdt)
            rd_mux = wdt_word;
        else if (a_pc)
            rd_mux = {20'h0_0000, pc_q};
    end

endmodule : clear_decrement_instr_exec

// ===== test/exec_monitor.sv
// Assertion checker for the clear and decrement execution block
`timescale 1ns/1ns
module exec_monitor (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Instruction stream and core state
    input wire logic instr_valid,
    input wire logic [11:0] instr_word,
    input wire logic instr_done,
    input wire logic skip_active,
    input wire logic [11:0] pc,
    input wire logic wdt_timeout
);
    // ==========================================================
    // Properties, all in the one core clock domain
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    done_follows_a: assert property (instr_valid |=> instr_done) else $error("done missing");
    done_idle_a: assert property (!instr_valid |=> !instr_done) else $error("stray done");
    pc_step_a: assert property (instr_valid |=> pc == $past(pc) + 12'h001) else $error("pc step");
    pc_hold_a: assert property (!instr_valid |=> $stable(pc)) else $error("pc moved");
    skip_cause_a: assert property ($rose(skip_active) |-> $past(instr_valid) && $past(instr_word[11:5]) == 7'h17)
        else $error("skip without decsz");
    skip_end_a: assert property (skip_active && instr_valid |=> !skip_active) else $error("skip stuck");
    skip_wait_a: assert property (skip_active && !instr_valid |=> skip_active) else $error("skip lost");
    wdt_clear_a: assert property (instr_valid && !skip_active && instr_word == 12'h004 |=> !wdt_timeout)
        else $error("expiry after clear");
    // One wait state on reads, always OKAY
    read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait");
    resp_okay_a: assert property (hresp == 1'b0) else $error("resp not okay");
    cover property (instr_valid && instr_word[11:5] == 7'h17 ##1 skip_active);
    cover property (wdt_timeout);
    cover property (instr_valid && instr_word[11:8] == 4'h4);
endmodule : exec_monitor

bind clear_decrement_instr_exec exec_monitor u_exec_monitor (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .instr_valid, .instr_word, .instr_done, .skip_active, .pc, .wdt_timeout);

// ===== test/clear_decrement_instr_exec_test.sv
// Self-checking testbench for the clear and decrement execution block
`timescale 1ns/1ns
module clear_decrement_instr_exec_test;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, instr_valid, instr_done, skip_active, wdt_timeout;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [11:0] instr_word, pc, pc0;
    int fail_count, cmp_count, i;

    // Short watchdog widths keep expiry near 16 cycles
    clear_decrement_instr_exec #(.PRE_W(2), .WDT_W(2)) u_clear_decrement_instr_exec (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .instr_valid(instr_valid), .instr_word(instr_word), .instr_done(instr_done),
        .skip_active(skip_active), .pc(pc), .wdt_timeout(wdt_timeout));

    // ==========================================================
    // Helpers
    initial
    begin
        hclk = 0;
        forever #10 hclk = ~hclk;
    end
    function automatic logic [7:0] f(input int n);
        return {1'b1, n[4:0], 2'b00};
    endfunction : f
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Single transfer; master waits for the slave, however long
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        @(posedge hclk iff hreadyout === 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk iff hreadyout === 1'b1);
        rd = hrdata;
    endtask : bus
    task rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(what, exp, rd & m);
    endtask : rdchk
    task exec(input logic [11:0] w);
        instr_valid <= 1'b1;
        instr_word <= w;
        @(posedge hclk);
    endtask : exec
    task idle();
        instr_valid <= 1'b0;
        @(posedge hclk);
    endtask : idle
    task print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Scenarios
    task t_bitclr();
        bus(1'b1, 8'h04, 32'h00000007);
        bus(1'b1, f(31), 32'h000000FF);
        for (i = 0; i < 8; i++)
        begin
            exec({4'h4, i[2:0], 5'h1F});
            idle();
            rdchk("bitclr", f(31), 32'hFF, (32'hFF << (i + 1)) & 32'hFF);
        end
        rdchk("bitclr flags", 8'h04, 32'h7, 32'h7);
        $display("test bitclr done");
    endtask : t_bitclr
    task t_dec();
        bus(1'b1, f(2), 32'h00000001);
        exec({7'h07, 5'd2});
        idle();
        rdchk("dec 01", f(2), 32'hFF, 32'h00);
        rdchk("dec z set", 8'h04, 32'h1, 32'h1);
        exec({7'h07, 5'd2});
        idle();
        rdchk("dec wrap", f(2), 32'hFF, 32'hFF);
        rdchk("dec z clr", 8'h04, 32'h1, 32'h0);
        $display("test dec done");
    endtask : t_dec
    task t_decsz();
        bus(1'b1, f(3), 32'h00000002);
        bus(1'b1, f(4), 32'h00000005);
        pc0 = pc;
        exec({7'h17, 5'd3});
        exec({7'h07, 5'd4});
        idle();
        rdchk("decsz 02", f(3), 32'hFF, 32'h01);
        rdchk("no skip", f(4), 32'hFF, 32'h04);
        // Flags cleared so a zero result that touched Z would show
        bus(1'b1, 8'h04, 32'h00000000);
        exec({7'h17, 5'd3});
        exec({7'h07, 5'd4});
        idle();
        rdchk("decsz 01", f(3), 32'hFF, 32'h00);
        rdchk("skipped", f(4), 32'hFF, 32'h04);
        rdchk("decsz flags", 8'h04, 32'h7, 32'h0);
        chk("pc", {20'h0, pc0 + 12'h004}, {20'h0, pc});
        $display("test decsz done");
    endtask : t_decsz
    task t_wdt();
        bus(1'b1, 8'h00, 32'h00000001);
        for (i = 0; i < 200 && wdt_timeout !== 1'b1; i++)
            @(negedge hclk);
        chk("expiry", 32'h1, {31'h0, wdt_timeout});
        @(posedge hclk);
        rdchk("to clr", 8'h04, 32'h4, 32'h0);
        // Stop the counters so the cleared value stays readable
        bus(1'b1, 8'h00, 32'h00000000);
        bus(1'b1, 8'h04, 32'h00000000);
        exec(12'h004);
        idle();
        rdchk("wdt zero", 8'h08, 32'hFFFFFFFF, 32'h0);
        rdchk("wdt flags", 8'h04, 32'h7, 32'h7);
        $display("test wdt done");
    endtask : t_wdt

    // ==========================================================
    // Main sequence and hang guard
    initial
    begin
        {hresetn, hsel, hwrite, instr_valid, fail_count, cmp_count} = 0;
        {htrans, haddr, hwdata, instr_word} = 0;
        hsize = 3'b010;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk("status rst", 8'h04, 32'h7, 32'h6);
        rdchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
        t_bitclr();
        t_dec();
        t_decsz();
        t_wdt();
        print_verdict();
    end
    initial
    begin
        repeat (5000) @(posedge hclk);
        fail_count++;
        print_verdict();
    end
endmodule : clear_decrement_instr_exec_test
